// file: fsc_defines.vh
`ifndef FSC_DEFINES_VH
`define FSC_DEFINES_VH
`define FSC_ADDR_FIXED      4'hc
`define FSC_REG_STATUS      4'h0
`define FSC_REG_SETUP       4'h1
`define FSC_REG_SIGCTL      4'h2
`define FSC_REG_SUPCTL      4'h3
`define FSC_REG_IND_AH      4'h4
`define FSC_REG_IND_AL      4'h5
`define FSC_REG_IND_BH      4'h6
`define FSC_REG_IND_BL      4'h7
`define FSC_REG_CHECK       4'h8
`define FSC_RST_STATUS      8'h00
`define FSC_RST_SETUP       8'h80
`define FSC_RST_SIGCTL      8'h21
`define FSC_RST_SUPCTL      8'h21
`define FSC_RST_OTHER       8'h00
`define FSC_ST_SUPPLY       7
`define FSC_ST_THERMAL      5
`define FSC_ST_SIGOVL       4
`define FSC_ST_SUPOVL       3
`define FSC_ST_REGUV        1
`define FSC_ST_CHECK        0
`define FSC_CLK_MHZ         40
`define FSC_US_UNIT         40
`define FSC_RESTART_MULT    255
`define FSC_SUP_DELAY_US    500
`define FSC_SUP_RESTART_MS  64
`define FSC_SUP_RESTART_CYC (`FSC_SUP_RESTART_MS * 1000 * `FSC_CLK_MHZ)
`endif

// file: fsc_regs.v
`timescale 1ns/10ps
`default_nettype none
`include "fsc_defines.vh"
module fsc_regs #(
  parameter SUP_RESTART_CYC = `FSC_SUP_RESTART_CYC // long count, shortenable
) (
  // clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // serial bus pins
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe_n,
  // address straps
  input  wire       addr_strap_bit0,
  input  wire       addr_strap_bit1,
  input  wire       addr_strap_bit2,
  // fault sources (levels from analog monitors)
  input  wire       supply_line_fault,
  input  wire       supply_enable,
  input  wire       thermal_fault,
  input  wire       regulator_undervoltage,
  input  wire       check_error,
  input  wire       signal_overcurrent,
  input  wire       supply_overcurrent,
  // channel inputs: signal_in and aux_in to debounce, channel_enable used directly
  input  wire       signal_in,
  input  wire       aux_in,
  input  wire       channel_enable,
  // outputs
  output wire       irq_n,
  output reg        signal_drive_en,
  output reg        supply_drive_en,
  output reg        signal_pulldown_enable,
  output reg        aux_pulldown_enable,
  output reg        sink_current_select,
  output reg  [1:0] signal_cutoff_current,
  output reg  [7:0] output_stage_mode,
  output reg        signal_filt,
  output reg        aux_filt
);
  // bus states
  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_WDAT = 3'd2;
  localparam S_RDAT = 3'd3;
  localparam S_IGN  = 3'd4;

  // synchronisers: first stage only feeds the second
  reg [1:0] scl_s1_q, scl_s2_q;
  reg [1:0] sda_s1_q, sda_s2_q;
  reg [2:0] strap_s1_q, strap_s2_q;
  reg [6:0] mon_s1_q, mon_s2_q;
  reg [2:0] in_s1_q, in_s2_q;
  reg       scl_q, sda_q;       // previous synchronised levels
  always @(posedge core_clk) begin
    scl_s1_q   <= {1'b0, scl_in};
    scl_s2_q   <= scl_s1_q;
    sda_s1_q   <= {1'b0, sda_in};
    sda_s2_q   <= sda_s1_q;
    strap_s1_q <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
    strap_s2_q <= strap_s1_q;
    mon_s1_q   <= {supply_line_fault, supply_enable, thermal_fault,
                   regulator_undervoltage, check_error,
                   signal_overcurrent, supply_overcurrent};
    mon_s2_q   <= mon_s1_q;
    in_s1_q    <= {signal_in, aux_in, channel_enable};
    in_s2_q    <= in_s1_q;
    scl_q      <= scl_s2_q[0];
    sda_q      <= sda_s2_q[0];
  end
  wire scl = scl_s2_q[0];
  wire sda = sda_s2_q[0];
  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start_c = scl & scl_q & sda_q & ~sda;
  wire stop_c  = scl & scl_q & ~sda_q & sda;
  wire m_sup = mon_s2_q[6], m_sen = mon_s2_q[5], m_thm = mon_s2_q[4];
  wire m_reg = mon_s2_q[3], m_chk = mon_s2_q[2];
  wire m_soc = mon_s2_q[1], m_loc = mon_s2_q[0];
  wire en_ch = in_s2_q[0];

  // register storage
  reg [7:0] status_q, setup_q, sigctl_q, supctl_q, check_q;
  reg [7:0] ind_q [0:3];
  reg [3:0] regidx_q;           // selected register

  // bus engine
  reg [2:0] st_q;
  reg [3:0] bit_q;              // 0..7 data, 8 ack slot
  reg [7:0] sh_q;
  reg       first_q;            // first write byte is register index
  reg       rw_q;
  reg       ack_q;              // pull sda low in ack slot
  reg       drv_q;              // drive read bit
  reg       rd_ok_q;            // status read got master ack
  reg       rd_stat_q;          // current read byte is status
  reg [7:0] snap_q;             // flags seen at read start
  reg       access_p;           // pulse: any register access
  reg       clr_p;              // pulse: status read completed
  reg [7:0] clr_mask_q;

  // readback mux, reserved status bits forced to zero
  function [7:0] rd_mux;
    input [3:0] idx;
    begin
      case (idx)
        `FSC_REG_STATUS: rd_mux = status_q & 8'hbb;
        `FSC_REG_SETUP:  rd_mux = setup_q;
        `FSC_REG_SIGCTL: rd_mux = sigctl_q;
        `FSC_REG_SUPCTL: rd_mux = supctl_q;
        `FSC_REG_CHECK:  rd_mux = check_q;
        default:         rd_mux = (idx < 4'h8) ? ind_q[idx[1:0]] : 8'h00;
      endcase
    end
  endfunction

  wire [6:0] own_addr = {`FSC_ADDR_FIXED, strap_s2_q};
  integer i;

  // serial engine: bits on scl rise, drive changes on scl fall
  always @(posedge core_clk) begin
    access_p <= 1'b0;
    clr_p    <= 1'b0;
    if (rst) begin
      st_q <= S_IDLE; bit_q <= 4'h0; sh_q <= 8'h00; first_q <= 1'b0;
      rw_q <= 1'b0; ack_q <= 1'b0; drv_q <= 1'b0; regidx_q <= 4'h0;
      setup_q <= `FSC_RST_SETUP; sigctl_q <= `FSC_RST_SIGCTL;
      supctl_q <= `FSC_RST_SUPCTL; check_q <= `FSC_RST_OTHER;
      for (i = 0; i < 4; i = i + 1) ind_q[i] <= `FSC_RST_OTHER;
      rd_stat_q <= 1'b0; snap_q <= 8'h00; clr_mask_q <= 8'h00;
    end else if (start_c) begin
      st_q <= S_ADDR; bit_q <= 4'h0; ack_q <= 1'b0; drv_q <= 1'b0;
    end else if (stop_c) begin
      st_q <= S_IDLE; ack_q <= 1'b0; drv_q <= 1'b0;
    end else if (st_q != S_IDLE && st_q != S_IGN) begin
      if (scl_rise && bit_q < 4'h8) begin
        // a read byte only moves on falls, never while scl is high
        if (st_q != S_RDAT)
          sh_q <= {sh_q[6:0], sda}; // msb first
        bit_q <= bit_q + 4'h1;
      end else if (scl_rise && bit_q == 4'h8) begin
        bit_q <= 4'h0;
        if (st_q == S_RDAT) begin
          if (sda) st_q <= S_IGN;   // master nack ends read
          if (!sda && rd_stat_q) begin
            clr_p      <= 1'b1;
            clr_mask_q <= snap_q;
          end
        end
      end else if (scl_fall && bit_q == 4'h8 && !ack_q
                   && st_q != S_RDAT) begin
        // ninth pulse: decide acknowledge
        if (st_q == S_ADDR) begin
          if (sh_q[7:1] == own_addr) begin
            ack_q <= 1'b1; rw_q <= sh_q[0];
            first_q <= ~sh_q[0];
          end else
            st_q <= S_IGN;
        end else begin
          ack_q <= 1'b1; access_p <= 1'b1;
          if (first_q) begin
            regidx_q <= sh_q[3:0];
            first_q  <= 1'b0;
          end else begin
            case (regidx_q)
              `FSC_REG_SETUP:  setup_q  <= sh_q;
              `FSC_REG_SIGCTL: sigctl_q <= sh_q;
              `FSC_REG_SUPCTL: supctl_q <= sh_q & 8'hbf;
              `FSC_REG_CHECK:  check_q  <= sh_q;
              default: if (regidx_q[3:2] == 2'b01)
                ind_q[regidx_q[1:0]] <= sh_q;
            endcase
            regidx_q <= regidx_q + 4'h1;
          end
        end
      end else if (scl_fall && ack_q) begin
        ack_q <= 1'b0;
        if (st_q == S_ADDR)
          st_q <= rw_q ? S_RDAT : S_WDAT;
        if (rw_q && st_q == S_ADDR || st_q == S_RDAT) begin
          sh_q <= rd_mux(regidx_q);
          rd_stat_q <= (regidx_q == `FSC_REG_STATUS);
          snap_q <= status_q;       // read begins after these set
          drv_q <= 1'b1; access_p <= 1'b1;
        end
      end else if (scl_fall && st_q == S_RDAT && bit_q < 4'h8) begin
        if (bit_q != 4'h0) sh_q <= {sh_q[6:0], 1'b1};
        else begin                  // master acked: load the next byte
          sh_q <= rd_mux(regidx_q);
          rd_stat_q <= (regidx_q == `FSC_REG_STATUS);
          snap_q <= status_q;
          drv_q <= 1'b1; access_p <= 1'b1;
        end
      end else if (scl_fall && st_q == S_RDAT && bit_q == 4'h8) begin
        drv_q <= 1'b0;              // release for master ack
        regidx_q <= regidx_q + 4'h1;
      end
    end
  end
  wire sda_low = ack_q | (drv_q & ~sh_q[7]);
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~sda_low;       // open drain, low enable drives

  // protection timers
  wire [1:0] tsel = sigctl_q[4:3];
  wire [13:0] dly_cyc = (14'd100 + {5'd0, tsel, 5'd0} + {6'd0, tsel, 4'd0}
                         + {8'd0, tsel, 1'b0}) * 14'd0 + 14'd0;
  function [13:0] sig_delay;
    input [1:0] s;
    begin
      sig_delay = (14'd100 + 14'd50 * {12'd0, s}) * `FSC_US_UNIT;
    end
  endfunction
  reg  [13:0] soc_cnt_q;
  reg  [7:0]  soc_per_q;
  reg  [13:0] soc_tick_q;
  reg         soc_off_q;
  reg  [14:0] loc_cnt_q;
  reg  [31:0] loc_rst_q;
  reg         loc_off_q;
  reg         sen_q;
  wire        sig_cut = soc_cnt_q >= sig_delay(tsel);
  wire        sup_dly_done = supctl_q[3] ||
                {17'd0, loc_cnt_q} >= (`FSC_SUP_DELAY_US * `FSC_US_UNIT);
  wire        sup_cut = m_loc && !supctl_q[4] && sup_dly_done;
  wire        sig_set = m_soc && sig_cut && !soc_off_q;
  wire        sup_set = sup_cut && !loc_off_q;
  wire        sig_restart_done = {24'd0, soc_per_q} == `FSC_RESTART_MULT;
  wire        sup_restart_done = loc_rst_q == SUP_RESTART_CYC;

  always @(posedge core_clk) begin
    if (rst) begin
      soc_cnt_q <= 14'd0; soc_per_q <= 8'd0; soc_tick_q <= 14'd0;
      soc_off_q <= 1'b0; loc_cnt_q <= 15'd0; loc_rst_q <= 32'd0;
      loc_off_q <= 1'b0;
    end else begin
      // overcurrent must persist for the delay before cutting
      soc_cnt_q <= (m_soc && !soc_off_q && !sig_cut) ? soc_cnt_q + 14'd1
                 : (m_soc ? soc_cnt_q : 14'd0);
      loc_cnt_q <= (m_loc && !loc_off_q && !sup_dly_done)
                 ? loc_cnt_q + 15'd1 : (m_loc ? loc_cnt_q : 15'd0);
      if (sig_set) begin
        soc_off_q <= 1'b1; soc_per_q <= 8'd0; soc_tick_q <= 14'd0;
      end else if (soc_off_q) begin
        if (sigctl_q[2]) begin      // latched until bus access
          if (access_p) soc_off_q <= 1'b0;
        end else if (sig_restart_done) begin // 255 delay periods
          soc_off_q <= 1'b0; soc_cnt_q <= 14'd0;
        end else if (soc_tick_q + 14'd1 >= sig_delay(tsel)) begin
          soc_tick_q <= 14'd0; soc_per_q <= soc_per_q + 8'd1;
        end else
          soc_tick_q <= soc_tick_q + 14'd1;
      end
      if (sup_set) begin
        loc_off_q <= 1'b1; loc_rst_q <= 32'd0;
      end else if (loc_off_q) begin
        if (supctl_q[2]) begin
          if (access_p) loc_off_q <= 1'b0;
        end else if (sup_restart_done) begin
          loc_off_q <= 1'b0; loc_cnt_q <= 15'd0;
        end else
          loc_rst_q <= loc_rst_q + 32'd1;
      end
    end
  end

  // status flags: set wins over the read clear
  wire [7:0] persist = {m_sup, 1'b0, m_thm,
                        soc_off_q & ~sigctl_q[2], loc_off_q & ~supctl_q[2],
                        1'b0, m_reg, 1'b0};
  wire [7:0] setv = {(m_sup & m_sen) | (m_sen & ~sen_q), 1'b0, m_thm,
                     sig_set, sup_set, 1'b0, m_reg, m_chk};
  always @(posedge core_clk) begin
    if (rst) begin
      status_q <= `FSC_RST_STATUS; sen_q <= 1'b0;
    end else begin
      sen_q <= m_sen;
      status_q <= ((status_q & ~(clr_p ? (clr_mask_q & ~persist) : 8'h00))
                   | setv) & 8'hbb;
    end
  end
  assign irq_n = ~|(status_q & 8'hbb);

  // debounce: input must hold steady for the chosen time
  function [11:0] db_cyc;
    input [1:0] s;
    begin
      case (s)
        2'd0:    db_cyc = 12'd0;
        2'd1:    db_cyc = 12'd5 * `FSC_US_UNIT;
        2'd2:    db_cyc = 12'd20 * `FSC_US_UNIT;
        default: db_cyc = 12'd100 * `FSC_US_UNIT;
      endcase
    end
  endfunction
  reg [11:0] dbs_q, dba_q;
  always @(posedge core_clk) begin
    if (rst) begin
      dbs_q <= 12'd0; dba_q <= 12'd0; signal_filt <= 1'b0;
      aux_filt <= 1'b0;
    end else begin
      if (in_s2_q[2] == signal_filt) dbs_q <= 12'd0;
      else if (dbs_q >= db_cyc(sigctl_q[1:0])) signal_filt <= in_s2_q[2];
      else dbs_q <= dbs_q + 12'd1;
      if (in_s2_q[1] == aux_filt) dba_q <= 12'd0;
      else if (dba_q >= db_cyc(supctl_q[1:0])) aux_filt <= in_s2_q[1];
      else dba_q <= dba_q + 12'd1;
    end
  end

  // control outputs from flops
  always @(posedge core_clk) begin
    if (rst) begin
      signal_drive_en <= 1'b0; supply_drive_en <= 1'b0;
      signal_pulldown_enable <= 1'b0; aux_pulldown_enable <= 1'b0;
      sink_current_select <= 1'b1; signal_cutoff_current <= 2'b01;
      output_stage_mode <= `FSC_RST_SETUP;
    end else begin
      signal_drive_en <= ~soc_off_q & ~status_q[5];
      supply_drive_en <= ~loc_off_q & ~status_q[5];
      signal_pulldown_enable <= sigctl_q[7] & ~en_ch;
      aux_pulldown_enable <= supctl_q[7];
      sink_current_select <= supctl_q[5];
      signal_cutoff_current <= sigctl_q[6:5];
      output_stage_mode <= setup_q;
    end
  end
  wire unused_ok = &{1'b0, dly_cyc, scl_s2_q[1], sda_s2_q[1]};
endmodule // fsc_regs
`default_nettype wire

// file: fsc_regs_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// watches the bank's pins only; all assertions share the core clock
module fsc_regs_monitor #(
  parameter SUP_RESTART_CYC = 200 // handed on from the design
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // bus side
  input wire logic scl_in,
  input wire logic sda_oe_n,
  // fault sources
  input wire logic supply_line_fault,
  input wire logic supply_enable,
  input wire logic thermal_fault,
  input wire logic regulator_undervoltage,
  input wire logic channel_enable,
  // outputs under watch
  input wire logic irq_n,
  input wire logic signal_drive_en,
  input wire logic supply_drive_en,
  input wire logic signal_pulldown_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // reset must leave the pin released and the interrupt quiet
  chk_rst_quiet: assert property (disable iff (1'b0)
    rst |=> sda_oe_n && irq_n) else $error("pin or irq active in reset");
  // sda only moves while scl is low, never while it is high
  chk_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("sda moved while scl high");
  // a driven or released bit must hold for three more core cycles after it changes
  chk_bit_holds: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*3])
    else $error("driven bit too short");
  chk_release_holds: assert property ($rose(sda_oe_n) |=> sda_oe_n [*3])
    else $error("released bit too short");
  // sync plus register latency is well under six cycles
  chk_hot_outputs_off: assert property (thermal_fault [*6] |->
    !signal_drive_en && !supply_drive_en) else $error("outputs on while hot");
  chk_hot_irq: assert property (thermal_fault [*6] |-> !irq_n)
    else $error("no irq on thermal fault");
  chk_supply_irq: assert property ((supply_line_fault && supply_enable) [*6]
    |-> !irq_n) else $error("no irq on supply line fault");
  chk_reguv_irq: assert property (regulator_undervoltage [*6] |-> !irq_n)
    else $error("no irq on regulator fault");
  chk_pd_off_enabled: assert property (channel_enable [*6] |->
    !signal_pulldown_enable) else $error("pulldown on while enabled");
endmodule // fsc_regs_monitor
`default_nettype wire

// file: fsc_i2c_master.sv
`timescale 1ns/10ps
`default_nettype none
// bus master model: 200 ns bit time, steps on 25 ns multiples
module fsc_i2c_master (
  // bus wires
  output logic     scl,
  output logic     sda_low,
  input wire logic sda
);
  // clock stands still high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // sda falls while scl high opens a frame
  task automatic start();
    sda_low = 1'b1;
    #100 scl = 1'b0;
  endtask
  // data moves two core cycles after scl falls, so the two edges
  // never land in the same synchroniser sample
  task automatic bit_io(input logic b, output logic r);
    #50 sda_low = !b;
    #50 scl = 1'b1;
    #75 r = sda;
    #25 scl = 1'b0;
  endtask
  // sda rises while scl high closes it
  task automatic stop();
    #50 sda_low = 1'b1;
    #50 scl = 1'b1;
    #100 sda_low = 1'b0;
    #100;
  endtask
  // eight bits msb first, then the receiver's acknowledge
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // master answers each byte; last byte gets no acknowledge
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule // fsc_i2c_master
`default_nettype wire

// file: tb_fsc_regs.sv
`timescale 1ns/10ps
`default_nettype none
// self-checking bench for the register bank behind the serial bus
module tb_fsc_regs;
  logic       core_clk, rst, m_scl, m_low;     // clock, reset, master
  logic [2:0] strap;                           // address straps
  logic       sup_f, sup_en, hot, reg_uv, chk_e, sig_oc, sup_oc, chan_en;
  logic       sda_oe_n, sda_out, irq_n, sig_en, sup_drv, sig_pd, aux_pd;
  logic       sink;                            // sink current select
  logic [1:0] cut_i;                           // cutoff current code
  logic [7:0] mode;                            // output stage setup
  int         num_errors, tests_run;
  int         fb[4] = '{7, 5, 1, 0};           // status bits to fault
  // open drain: pull-up wins unless a party pulls low
  wire logic  sda_bus = !m_low && (sda_oe_n || sda_out);
  fsc_regs #(.SUP_RESTART_CYC(200)) dut (
    .core_clk(core_clk), .rst(rst), .scl_in(m_scl), .sda_in(sda_bus),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap_bit0(strap[0]),
    .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
    .supply_line_fault(sup_f), .supply_enable(sup_en),
    .thermal_fault(hot), .regulator_undervoltage(reg_uv),
    .check_error(chk_e), .signal_overcurrent(sig_oc),
    .supply_overcurrent(sup_oc), .signal_in(1'b0), .aux_in(1'b0),
    .channel_enable(chan_en), .irq_n(irq_n), .signal_drive_en(sig_en),
    .supply_drive_en(sup_drv), .signal_pulldown_enable(sig_pd),
    .aux_pulldown_enable(aux_pd), .sink_current_select(sink),
    .signal_cutoff_current(cut_i), .output_stage_mode(mode),
    .signal_filt(), .aux_filt());
  fsc_i2c_master m (.scl(m_scl), .sda_low(m_low), .sda(sda_bus));
  // 40 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // start plus own address, which must be acknowledged
  task automatic open_xfer(input logic rd);
    logic a;
    @(negedge core_clk);
    m.start();
    m.send({4'hc, strap, rd}, a);
    check({7'h0, a}, 8'h01);
  endtask
  task automatic set_idx(input logic [3:0] idx);
    logic a;
    open_xfer(1'b0);
    m.send({4'h0, idx}, a);
    check({7'h0, a}, 8'h01);
  endtask
  task automatic wr_reg(input logic [3:0] idx, input logic [7:0] d);
    logic a;
    set_idx(idx);
    m.send(d, a);
    check({7'h0, a}, 8'h01);
    m.stop();
  endtask
  // two bytes so the first is acknowledged, which a status clear needs
  task automatic rd_chk(input logic [3:0] idx, input logic [7:0] e);
    logic [7:0] d, n;
    set_idx(idx);
    m.stop();
    open_xfer(1'b1);
    m.recv(1'b0, d);
    m.recv(1'b1, n);
    m.stop();
    check(d, e);
  endtask
  task automatic t_reset();
    logic [7:0] rv[4] = '{8'h00, 8'h80, 8'h21, 8'h21};
    for (int i = 0; i < 4; i++) rd_chk(4'(i), rv[i]);
    check({irq_n, sink, cut_i, 4'h0}, 8'hd0);
    check(mode, 8'h80);
    $display("test reset done");
  endtask
  task automatic t_ctl();
    for (int k = 0; k < 4; k++) begin
      wr_reg(4'h2, {1'b1, 2'(k), 5'h01});
      rd_chk(4'h2, {1'b1, 2'(k), 5'h01});
      check({6'h0, cut_i}, 8'(k));
      check({7'h0, sig_pd}, 8'h01);
    end
    @(negedge core_clk) chan_en = 1'b1;
    repeat (8) @(negedge core_clk);
    check({7'h0, sig_pd}, 8'h00);
    wr_reg(4'h3, 8'h81);
    check({6'h0, aux_pd, sink}, 8'h02);
    wr_reg(4'h3, 8'h21);
    check({6'h0, aux_pd, sink}, 8'h01);
    for (int i = 4; i < 9; i++) begin
      wr_reg(4'(i), 8'(i * 17));
      rd_chk(4'(i), 8'(i * 17));
    end
    $display("test control done");
  endtask
  // foreign addresses are ignored for two strap settings
  task automatic t_addr();
    logic a;
    for (int s = 0; s < 2; s++) begin
      strap = s ? 3'b010 : 3'b101;
      @(negedge core_clk);
      m.start();
      m.send({4'hc, ~strap, 1'b0}, a);
      check({7'h0, a}, 8'h00);
      m.stop();
      m.start();
      m.send({4'hd, strap, 1'b0}, a);
      check({7'h0, a}, 8'h00);
      m.stop();
      rd_chk(4'h3, 8'h21);
    end
    $display("test address done");
  endtask
  task automatic set_fault(input int b, input logic v);
    case (b)
      7: begin
        sup_en = 1'b1;
        sup_f = v;
      end
      5: hot = v;
      1: reg_uv = v;
      default: chk_e = v;
    endcase
  endtask
  // set, hold through a read, then clear after recovery
  task automatic t_fault(input int b);
    @(negedge core_clk);
    set_fault(b, 1'b1);
    repeat (8) @(negedge core_clk);
    check({7'h0, irq_n}, 8'h00);
    if (b == 5) check({6'h0, sig_en, sup_drv}, 8'h00);
    rd_chk(4'h0, 8'h01 << b);
    set_fault(b, 1'b0);
    rd_chk(4'h0, 8'h01 << b);
    rd_chk(4'h0, 8'h00);
    check({7'h0, irq_n}, 8'h01);
    $display("test fault %0d done", b);
  endtask
  task automatic pulse_oc();
    @(negedge core_clk) sup_oc = 1'b1;
    repeat (10) @(negedge core_clk);
    sup_oc = 1'b0;
    repeat (10) @(negedge core_clk);
  endtask
  // latched, auto restart and disabled supply cutoff
  task automatic t_supply();
    wr_reg(4'h3, 8'h2c);
    pulse_oc();
    check({7'h0, sup_drv}, 8'h00);
    rd_chk(4'h0, 8'h08);
    check({7'h0, sup_drv}, 8'h01);
    wr_reg(4'h3, 8'h28);
    pulse_oc();
    check({7'h0, sup_drv}, 8'h00);
    repeat (300) @(negedge core_clk);
    check({7'h0, sup_drv}, 8'h01);
    rd_chk(4'h0, 8'h08);
    wr_reg(4'h3, 8'h38);
    pulse_oc();
    check({7'h0, sup_drv}, 8'h01);
    $display("test supply done");
  endtask
  // latched signal cutoff after the shortest delay, freed by access
  task automatic t_signal();
    wr_reg(4'h2, 8'h04);
    @(negedge core_clk) sig_oc = 1'b1;
    repeat (4020) @(negedge core_clk);
    check({7'h0, sig_en}, 8'h00);
    sig_oc = 1'b0;
    repeat (10) @(negedge core_clk);
    check({7'h0, sig_en}, 8'h00);
    rd_chk(4'h0, 8'h10);
    check({7'h0, sig_en}, 8'h01);
    $display("test signal done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    rst = 1'b1;
    strap = 3'b101;
    {sup_f, sup_en, hot, reg_uv, chk_e, sig_oc, sup_oc, chan_en} = '0;
    num_errors = 0;
    tests_run = 0;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    t_reset();
    t_ctl();
    t_addr();
    foreach (fb[i]) t_fault(fb[i]);
    t_supply();
    t_signal();
    close_out();
  end
  // run needs about 20k cycles; cut a hang well beyond that
  initial begin
    #1500000;
    num_errors++;
    close_out();
  end
endmodule // tb_fsc_regs
bind fsc_regs fsc_regs_monitor #(.SUP_RESTART_CYC(SUP_RESTART_CYC)) u_mon (
  .core_clk(core_clk), .rst(rst), .scl_in(scl_in), .sda_oe_n(sda_oe_n),
  .supply_line_fault(supply_line_fault), .supply_enable(supply_enable),
  .thermal_fault(thermal_fault),
  .regulator_undervoltage(regulator_undervoltage),
  .channel_enable(channel_enable), .irq_n(irq_n),
  .signal_drive_en(signal_drive_en), .supply_drive_en(supply_drive_en),
  .signal_pulldown_enable(signal_pulldown_enable));
`default_nettype wire
